// [rtl/adcctl_regs.svh]
`ifndef ADCCTL_REGS_SVH
`define ADCCTL_REGS_SVH

// Register offsets (byte addresses)
`define ADCCTL_CTRL_OFS 8'h00
`define ADCCTL_STAT_OFS 8'h04
`define ADCCTL_RESULT_OFS 8'h08
`define ADCCTL_IRQ_STAT_OFS 8'h0C
`define ADCCTL_IRQ_MASK_OFS 8'h10
`define ADCCTL_RESET_OFS 8'h14

// Control register fields
`define ADCCTL_CTRL_RESET 16'h0600
`define ADCCTL_CTRL_WMASK 16'h1FFF
`define ADCCTL_DIV_HI 12
`define ADCCTL_DIV_LO 10
`define ADCCTL_ACQ_HI 9
`define ADCCTL_ACQ_LO 8
`define ADCCTL_START_EN_BIT 7
`define ADCCTL_BUSY_EN_BIT 6
`define ADCCTL_POWER_BIT 5
`define ADCCTL_MODE_HI 4
`define ADCCTL_MODE_LO 3
`define ADCCTL_TYPE_HI 2
`define ADCCTL_TYPE_LO 0

// Conversion type codes
`define ADCCTL_TYPE_PIN 3'h0
`define ADCCTL_TYPE_TMR2 3'h1
`define ADCCTL_TYPE_TMR1 3'h2
`define ADCCTL_TYPE_SINGLE 3'h3
`define ADCCTL_TYPE_CONT 3'h4
`define ADCCTL_TYPE_LOGIC 3'h5

// Input mode codes
`define ADCCTL_MODE_RSVD 2'h3

// Interrupt bits
`define ADCCTL_IRQ_DONE_BIT 0

// Conversion timing
`define ADCCTL_BIT_TRIAL_CLKS 8'h13
`define ADCCTL_DIV_MAX_CODE 3'h5

`endif

// [rtl/adcctl_pkg.sv]
package adcctl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACQ,
        ST_CONV
    } adcctl_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } adcctl_bus_t;

    typedef struct packed {
        logic ext_start;
        logic tmr1_ovf;
        logic tmr2_ovf;
        logic logic_trig;
    } adcctl_trig_t;
endpackage : adcctl_pkg

// [rtl/adcctl_clkdiv.sv]
`include "adcctl_regs.svh"

module adcctl_clkdiv (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Control
    input wire logic run,
    input wire logic [2:0] div_code,
    // Tick out
    output logic tick
);
    typedef struct packed {
        logic [4:0] cnt;
        logic tick;
    } adcctl_div_st_t;

    adcctl_div_st_t st_r;
    adcctl_div_st_t st_nxt;
    logic [4:0] limit;

    function automatic logic [4:0] div_limit(input logic [2:0] code);
        logic [2:0] c;
        c = (code > `ADCCTL_DIV_MAX_CODE) ? `ADCCTL_DIV_MAX_CODE : code;
        div_limit = 5'((6'h01 << c) - 6'h01);
    endfunction : div_limit

    always_comb begin
        limit = div_limit(div_code);
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!run) begin
            st_nxt.cnt = 5'h00;
        end else if (st_r.cnt >= limit) begin
            st_nxt.cnt = 5'h00;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule : adcctl_clkdiv

// [rtl/adcctl_result_mem.sv]
module adcctl_result_mem #(
    parameter int WIDTH = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Write side
    input wire logic wr,
    input wire logic [WIDTH-1:0] wdata,
    // Read side
    output logic [WIDTH-1:0] rdata
);
    typedef struct packed {
        logic [WIDTH-1:0] word;
    } adcctl_mem_st_t;

    adcctl_mem_st_t st_r;
    adcctl_mem_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (wr) begin
            st_nxt.word = wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.word;
endmodule : adcctl_result_mem

// [rtl/adcctl_top.sv]
// Added by the designer: strobed register access and the placing of the registers.
`include "adcctl_regs.svh"

module adcctl_top #(
    parameter int RES_BITS = 12
) (
    // Clock, reset, enable
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic CE,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // Trigger sources
    input wire logic EXT_START_N,
    input wire logic FIRST_TIMER_OVF,
    input wire logic SECOND_TIMER_OVF,
    input wire logic LOGIC_ARRAY_TRIG,
    // Converter side
    input wire logic [RES_BITS-1:0] SAR_RESULT,
    output logic CONV_POWER,
    output logic [1:0] INPUT_MODE,
    output logic SAMPLE,
    output logic BUSY_PIN,
    output logic BUSY_PIN_OE,
    // Interrupt
    output logic IRQ
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [15:0] ctrl;
        adcctl_pkg::adcctl_state_t state;
        logic [4:0] cnt;
        logic cont_run;
        logic single_pend;
        logic ext_d;
        logic ready;
        logic irq_stat;
        logic irq_mask;
        logic [31:0] rdata;
        logic busy;
        logic irq;
        logic sample;
    } adcctl_st_t;

    adcctl_st_t st_r;
    adcctl_st_t st_nxt;
    adcctl_pkg::adcctl_bus_t bus;
    adcctl_pkg::adcctl_trig_t trig;
    logic tick;
    logic done;
    logic start_hit;
    logic [RES_BITS-1:0] result;
    logic [2:0] ctype;
    logic [4:0] acq_len;
    logic conv_run;

    function automatic logic [4:0] acq_clocks(input logic [1:0] code);
        acq_clocks = 5'(6'h02 << code);
    endfunction : acq_clocks

    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    assign trig = '{ext_start: ~EXT_START_N, tmr1_ovf: FIRST_TIMER_OVF,
                    tmr2_ovf: SECOND_TIMER_OVF, logic_trig: LOGIC_ARRAY_TRIG};
    assign ctype = st_r.ctrl[`ADCCTL_TYPE_HI:`ADCCTL_TYPE_LO];
    assign acq_len = acq_clocks(st_r.ctrl[`ADCCTL_ACQ_HI:`ADCCTL_ACQ_LO]);

    ////////////////////////////////////////////////////////////////////////////
    // Converter clock
    adcctl_clkdiv u_div (
        .clk(CLOCK),
        .nrst(NRST),
        .ce(CE),
        .run(conv_run),
        .div_code(st_r.ctrl[`ADCCTL_DIV_HI:`ADCCTL_DIV_LO]),
        .tick(tick)
    );

    // Divider phase restarts with each conversion, so acquisition is exact
    assign conv_run = st_nxt.state != adcctl_pkg::ST_IDLE;
    assign done = (st_r.state == adcctl_pkg::ST_CONV) && tick && (st_r.cnt == 5'h00);

    adcctl_result_mem #(.WIDTH(RES_BITS)) u_res (
        .clk(CLOCK),
        .nrst(NRST),
        .ce(CE),
        .wr(done),
        .wdata(SAR_RESULT),
        .rdata(result)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Trigger selection
    always_comb begin
        start_hit = 1'b0;
        case (ctype)
            `ADCCTL_TYPE_PIN: start_hit = trig.ext_start && !st_r.ext_d;
            `ADCCTL_TYPE_TMR2: start_hit = trig.tmr2_ovf;
            `ADCCTL_TYPE_TMR1: start_hit = trig.tmr1_ovf;
            `ADCCTL_TYPE_SINGLE: start_hit = st_r.single_pend;
            `ADCCTL_TYPE_LOGIC: start_hit = trig.logic_trig;
            default: start_hit = 1'b0;
        endcase
        start_hit = start_hit && st_r.ctrl[`ADCCTL_START_EN_BIT];
        if (st_r.cont_run) begin
            start_hit = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [15:0] new_ctrl;
        logic wr_ctrl;
        new_ctrl = (bus.wdata[15:0] & `ADCCTL_CTRL_WMASK);
        wr_ctrl = bus.wr && (bus.addr == `ADCCTL_CTRL_OFS);
        st_nxt = st_r;
        st_nxt.ext_d = trig.ext_start;
        st_nxt.rdata = 32'h0000_0000;

        // Conversion sequencer
        case (st_r.state)
            adcctl_pkg::ST_IDLE: begin
                if (start_hit && st_r.ctrl[`ADCCTL_POWER_BIT]) begin
                    st_nxt.state = adcctl_pkg::ST_ACQ;
                    st_nxt.cnt = acq_len - 5'h01;
                    st_nxt.single_pend = 1'b0;
                end
            end
            adcctl_pkg::ST_ACQ: begin
                if (tick) begin
                    if (st_r.cnt == 5'h00) begin
                        st_nxt.state = adcctl_pkg::ST_CONV;
                        st_nxt.cnt = 5'(`ADCCTL_BIT_TRIAL_CLKS - 8'h01);
                    end else begin
                        st_nxt.cnt = st_r.cnt - 5'h01;
                    end
                end
            end
            adcctl_pkg::ST_CONV: begin
                if (tick) begin
                    if (st_r.cnt == 5'h00) begin
                        st_nxt.state = adcctl_pkg::ST_IDLE;
                        if (ctype == `ADCCTL_TYPE_SINGLE) begin
                            st_nxt.ctrl[`ADCCTL_TYPE_HI:`ADCCTL_TYPE_LO] = `ADCCTL_TYPE_PIN;
                        end
                    end else begin
                        st_nxt.cnt = st_r.cnt - 5'h01;
                    end
                end
            end
            default: st_nxt.state = adcctl_pkg::ST_IDLE;
        endcase

        // Continuous mode: latched by enable, dropped by type or power change
        if (ctype == `ADCCTL_TYPE_CONT && st_r.ctrl[`ADCCTL_START_EN_BIT]
                && st_r.ctrl[`ADCCTL_POWER_BIT]) begin
            st_nxt.cont_run = 1'b1;
        end
        if (wr_ctrl) begin
            st_nxt.ctrl = new_ctrl;
            if (new_ctrl[`ADCCTL_TYPE_HI:`ADCCTL_TYPE_LO] == `ADCCTL_TYPE_SINGLE
                    && new_ctrl[`ADCCTL_START_EN_BIT]) begin
                st_nxt.single_pend = 1'b1;
            end
            if (new_ctrl[`ADCCTL_TYPE_HI:`ADCCTL_TYPE_LO] != ctype
                    || !new_ctrl[`ADCCTL_POWER_BIT]) begin
                st_nxt.cont_run = 1'b0;
                st_nxt.single_pend = new_ctrl[`ADCCTL_TYPE_HI:`ADCCTL_TYPE_LO] == `ADCCTL_TYPE_SINGLE
                    && new_ctrl[`ADCCTL_START_EN_BIT];
            end
            if (!new_ctrl[`ADCCTL_POWER_BIT]) begin
                st_nxt.state = adcctl_pkg::ST_IDLE;
            end
        end

        // Reads, and the clear-on-read of the ready flag
        if (bus.rd) begin
            if (bus.addr == `ADCCTL_CTRL_OFS) begin
                st_nxt.rdata = {16'h0000, st_r.ctrl};
            end else if (bus.addr == `ADCCTL_STAT_OFS) begin
                st_nxt.rdata = {30'h0, st_r.busy, st_r.ready};
            end else if (bus.addr == `ADCCTL_RESULT_OFS) begin
                st_nxt.rdata = 32'(result) << 16;
                st_nxt.ready = 1'b0;
            end else if (bus.addr == `ADCCTL_IRQ_STAT_OFS) begin
                st_nxt.rdata = {31'h0, st_r.irq_stat};
            end else if (bus.addr == `ADCCTL_IRQ_MASK_OFS) begin
                st_nxt.rdata = {31'h0, st_r.irq_mask};
            end else begin
                st_nxt.rdata = 32'h0000_0000;
            end
        end

        // Interrupt registers
        if (bus.wr && bus.addr == `ADCCTL_IRQ_STAT_OFS && bus.wdata[`ADCCTL_IRQ_DONE_BIT]) begin
            st_nxt.irq_stat = 1'b0;
        end
        if (bus.wr && bus.addr == `ADCCTL_IRQ_MASK_OFS) begin
            st_nxt.irq_mask = bus.wdata[`ADCCTL_IRQ_DONE_BIT];
        end
        if (done) begin
            st_nxt.ready = 1'b1;
            st_nxt.irq_stat = 1'b1;
        end

        // Digital interface reset: any write restores defaults, except the result word, which keeps its last value
        if (bus.wr && bus.addr == `ADCCTL_RESET_OFS) begin
            st_nxt.ctrl = `ADCCTL_CTRL_RESET;
            st_nxt.state = adcctl_pkg::ST_IDLE;
            st_nxt.cnt = 5'h00;
            st_nxt.cont_run = 1'b0;
            st_nxt.single_pend = 1'b0;
            st_nxt.ready = 1'b0;
            st_nxt.irq_stat = 1'b0;
            st_nxt.irq_mask = 1'b0;
        end

        st_nxt.busy = st_nxt.state != adcctl_pkg::ST_IDLE;
        st_nxt.sample = st_nxt.state == adcctl_pkg::ST_ACQ;
        st_nxt.irq = st_nxt.irq_stat && st_nxt.irq_mask;
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            st_r <= '{ctrl: `ADCCTL_CTRL_RESET, state: adcctl_pkg::ST_IDLE, default: '0};
        end else if (CE) begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign RDATA = st_r.rdata;
    assign CONV_POWER = st_r.ctrl[`ADCCTL_POWER_BIT];
    assign INPUT_MODE = st_r.ctrl[`ADCCTL_MODE_HI:`ADCCTL_MODE_LO];
    assign SAMPLE = st_r.sample;
    assign BUSY_PIN = st_r.busy;
    assign BUSY_PIN_OE = st_r.ctrl[`ADCCTL_BUSY_EN_BIT];
    assign IRQ = st_r.irq;
endmodule : adcctl_top

// [tb/adcctl_asserts.sv]
module adcctl_chk (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic CE,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    // Converter side
    input wire logic CONV_POWER,
    input wire logic [1:0] INPUT_MODE,
    input wire logic SAMPLE,
    input wire logic BUSY_PIN,
    input wire logic BUSY_PIN_OE,
    input wire logic IRQ
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    wire wc = WR && CE && ADDR == 8'h00;
    logic [10:0] bcnt_r;
    ////////////////////////////////////////////////////////////
    // Length of the current busy stretch
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST)
            bcnt_r <= 11'h000;
        else if (CE)
            bcnt_r <= BUSY_PIN ? bcnt_r + 11'h001 : 11'h000;
    end
    ////////////////////////////////////////////////////////////
    property p_power; wc |=> CONV_POWER == $past(WDATA[5]); endproperty
    property p_busy_oe; wc |=> BUSY_PIN_OE == $past(WDATA[6]); endproperty
    property p_mode; wc |=> INPUT_MODE == $past(WDATA[4:3]); endproperty
    property p_rsvd; RD && CE && ADDR == 8'h00 |=> RDATA[31:13] == 19'h00000; endproperty
    property p_pdown; !CONV_POWER && $past(!CONV_POWER) |-> !BUSY_PIN; endproperty
    property p_sample; SAMPLE |-> BUSY_PIN; endproperty
    property p_busy_min; $rose(BUSY_PIN) |-> (BUSY_PIN || !CONV_POWER) [*8]; endproperty
    property p_busy_max; bcnt_r <= 11'h46A; endproperty
    property p_irq_fall; $fell(IRQ) |-> $past(WR) || $past(WR, 2); endproperty
    a_power: assert property (p_power) else $error("power state wrong");
    a_busy_oe: assert property (p_busy_oe) else $error("busy pin enable wrong");
    a_mode: assert property (p_mode) else $error("input mode wrong");
    a_rsvd: assert property (p_rsvd) else $error("reserved control bits set");
    a_pdown: assert property (p_pdown) else $error("busy while powered down");
    a_sample: assert property (p_sample) else $error("sample outside busy");
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
    a_busy_max: assert property (p_busy_max) else $error("busy too long");
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
    c_conv: cover property ($fell(BUSY_PIN));
    c_irq: cover property ($rose(IRQ));
    c_oe: cover property ($rose(BUSY_PIN) && BUSY_PIN_OE);
endmodule : adcctl_chk

bind adcctl_top adcctl_chk u_adcctl_chk (.CLOCK, .NRST, .CE, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .CONV_POWER, .INPUT_MODE, .SAMPLE, .BUSY_PIN, .BUSY_PIN_OE, .IRQ);

// [tb/tb.sv]
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLOCK = 1'b0, NRST = 1'b0, CE = 1'b1, WR = 1'b0, RD = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, RDATA, rv;
    logic [3:0] trg = 4'h0;
    logic [11:0] SAR_RESULT = 12'hA5C;
    logic CONV_POWER, SAMPLE, BUSY_PIN, BUSY_PIN_OE, IRQ, bz = 1'b0;
    logic [1:0] INPUT_MODE;
    int failures = 0, total_checks = 0, cyc = 0, scnt = 0, nconv = 0, s0, n0, n1;
    int ty[3] = '{1, 2, 5};
    int ix[3] = '{2, 1, 3};
    always #2.5 CLOCK = ~CLOCK;
    adcctl_top u_adcctl_top (.CLOCK, .NRST, .CE, .ADDR, .WDATA, .WR, .RD, .RDATA, .EXT_START_N(!trg[0]),
        .FIRST_TIMER_OVF(trg[1]), .SECOND_TIMER_OVF(trg[2]), .LOGIC_ARRAY_TRIG(trg[3]), .SAR_RESULT,
        .CONV_POWER, .INPUT_MODE, .SAMPLE, .BUSY_PIN, .BUSY_PIN_OE, .IRQ);
    ////////////////////////////////////////////////////////////
    // Sample cycles, conversion starts, run limit
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        bz <= BUSY_PIN;
        if (SAMPLE === 1'b1)
            scnt <= scnt + 1;
        if (BUSY_PIN === 1'b1 && bz !== 1'b1)
            nconv <= nconv + 1;
        if (cyc == 40000) begin
            failures++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic close_out();
        if (failures == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        @(negedge CLOCK);
        `CHK("rdata", e, RDATA)
        @(posedge CLOCK);
    endtask : rc
    task automatic pulse(input int i);
        trg <= 4'h1 << i;
        @(posedge CLOCK);
        trg <= 4'h0;
        repeat (4) @(posedge CLOCK);
    endtask : pulse
    task automatic idle();
        repeat (3) @(posedge CLOCK);
        for (int i = 0; i < 2000 && BUSY_PIN !== 1'b0; i++)
            @(posedge CLOCK);
    endtask : idle
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge CLOCK);
        NRST <= 1'b1;
        @(posedge CLOCK);
        rc(8'h00, 32'h0600);
        wr(8'h00, 32'hFFFF);
        rc(8'h00, 32'h1FFF);
        @(negedge CLOCK);
        `CHK("mode", 2'h3, INPUT_MODE)
        `CHK("busy_oe", 1'b1, BUSY_PIN_OE)
        `CHK("power", 1'b1, CONV_POWER)
        @(posedge CLOCK);
        wr(8'h00, 32'h0023);
        repeat (1000) @(posedge CLOCK);
        `CHK("starts", 0, nconv)
        for (int d = 0; d < 6; d++)
            for (int a = 0; a < 4; a++) begin
                s0 = scnt;
                wr(8'h00, {19'h0, d[2:0], a[1:0], 8'hE3});
                idle();
                `CHK("sample", (2 << a) << d, scnt - s0)
                rc(8'h00, {19'h0, d[2:0], a[1:0], 8'hE0});
                rc(8'h04, 32'h1);
                rc(8'h08, 32'h0A5C_0000);
                rc(8'h04, 32'h0);
            end
        wr(8'h00, 32'h0020);
        n0 = nconv;
        pulse(0);
        `CHK("pin_off", n0, nconv)
        wr(8'h00, 32'h00A0);
        pulse(0);
        idle();
        `CHK("pin_on", n0 + 1, nconv)
        for (int k = 0; k < 3; k++) begin
            wr(8'h00, 32'h00A0 | ty[k]);
            n0 = nconv;
            pulse(ix[(k + 1) % 3]);
            `CHK("wrong_src", n0, nconv)
            pulse(ix[k]);
            idle();
            `CHK("right_src", n0 + 1, nconv)
        end
        n0 = nconv;
        wr(8'h00, 32'h00A4);
        repeat (100) @(posedge CLOCK);
        n1 = nconv;
        `CHK("cont", 1'b1, n1 - n0 >= 2)
        wr(8'h00, 32'h0024);
        repeat (100) @(posedge CLOCK);
        `CHK("cont_kept", 1'b1, nconv - n1 >= 2)
        wr(8'h00, 32'h0020);
        idle();
        n1 = nconv;
        repeat (100) @(posedge CLOCK);
        `CHK("cont_stop", n1, nconv)
        CE <= 1'b0;
        wr(8'h00, 32'h0000);
        CE <= 1'b1;
        rc(8'h00, 32'h0020);
        wr(8'h10, 32'h1);
        wr(8'h0C, 32'h1);
        rc(8'h0C, 32'h0);
        `CHK("irq_clr", 1'b0, IRQ)
        wr(8'h00, 32'h00A3);
        wr(8'h00, 32'h0023);
        idle();
        rc(8'h0C, 32'h1);
        `CHK("irq_set", 1'b1, IRQ)
        wr(8'h10, 32'h0);
        rc(8'hFC, 32'h0);
        `CHK("irq_mask", 1'b0, IRQ)
        wr(8'h14, 32'h0);
        rc(8'h00, 32'h0600);
        close_out();
    end
endmodule : tb
